// >>> src/drc_pkg.sv
// Package for the DRAM timing and refresh control block.
package drc_pkg;

	// Register indices; byte address is four times the index.
	localparam logic [3:0] RegDramCfgIdx = 4'h0;
	localparam logic [3:0] RegRefCtlIdx  = 4'h1;
	localparam logic [3:0] RegRefCntIdx  = 4'h2;
	localparam logic [3:0] RegRefPerIdx  = 4'h3;

	localparam logic [15:0] DramCfgReset  = 16'h0000;
	localparam logic [15:0] RefCtlReset   = 16'h0000;
	localparam logic [15:0] DramCfgWrMask = 16'hFFB7;
	localparam logic [15:0] RefCtlWrMask  = 16'h003F;

	// Field positions of the DRAM configuration register.
	localparam int PosPrecharge = 15;
	localparam int PosRasCas    = 14;
	localparam int PosCbrRas    = 12;
	localparam int PosWrCol     = 10;
	localparam int PosRdCol     = 8;
	localparam int PosIdle      = 7;
	localparam int PosPage      = 5;
	localparam int PosRasHold   = 4;
	localparam int PosWidth     = 2;
	localparam int PosRowShift  = 0;

	// Field positions of the refresh control/status register.
	localparam int PosMatchFlag = 6;
	localparam int PosMatchIe   = 5;
	localparam int PosClkSel    = 2;
	localparam int PosRefEn     = 1;
	localparam int PosRefMode   = 0;

	// Base values of the documented timings; precharge and CBR RAS ones in half cycles.
	localparam logic [3:0] PrechargeHalfBase = 4'h3;
	localparam logic [3:0] CbrRasHalfBase    = 4'h5;
	localparam logic [2:0] ColCyclesBase     = 3'h2;
	localparam logic [3:0] RowShiftBase      = 4'h9;
	localparam int DivWidth = 12;

	typedef struct packed {
		logic       prechargeSelect;
		logic       rasCasDelaySelect;
		logic [1:0] cbrRasWidth;
		logic [1:0] writeColumnCycles;
		logic [1:0] readColumnCycles;
		logic       idleAfterRead;
		logic       pageModeEnable;
		logic       rasHoldMode;
		logic       dramWidthSelect;
		logic [1:0] rowShiftSelect;
	} drc_cfg_type;

	typedef struct packed {
		logic [3:0] prechargeHalf;
		logic [1:0] rowCycles;
		logic [3:0] cbrRasHalf;
		logic [2:0] writeCycles;
		logic [2:0] readCycles;
		logic       writeWaitOn;
		logic       readWaitOn;
		logic       idleAfterRead;
		logic       pageMode;
		logic       rasDown;
		logic       wide;
		logic [3:0] rowShift;
	} drc_timing_type;

endpackage

// >>> src/drc_refresh_control.sv
// DRAM configuration registers, refresh timer and refresh request logic.
`timescale 1ns/1ps
// Functional notes
// - Both registers reset to zero, kept otherwise.
// - Precharge select: 1.5 or 2.5 cycles.
// - RAS-CAS delay: one or two cycles.
// - Refresh RAS width 2.5 to 5.5 cycles.
// - Write column 2..5 cycles, wait codes 10/11.
// - Read column 2..5 cycles, wait codes 10/11.
// - Optional idle cycle after DRAM read.
// - Page mode enable turns on bursts.
// - RAS hold mode: up or down.
// - Width select: 8 or 16 bits.
// - Row shift 9 to 12 bits.
// - Counter equals constant sets match flag.
// - No match while both untouched since reset.
// - Flag clears by read-then-write-zero.
// - Interrupt enable gates match interrupt.
// - Clock select stops or divides counter clock.
// - Refresh enable turns on refresh.
// - Self-refresh entered once access ends.
// - CBR refresh at compare interval.
// - Timer requests ignored in self-refresh.
// - Counter is eight bits, upper byte zero.
// - Match clears counter with flag set.
// - Request pends; newer match supersedes it.
// - Interrupt held until flag cleared.
module drc_refresh_control (
	input  wire logic                   ref_clk,
	input  wire logic                   reset,
	input  wire logic [3:0]             regAddr,
	input  wire logic [15:0]            regWrData,
	input  wire logic                   regWrite,
	input  wire logic                   regRead,
	output logic [15:0]                 regRdData,
	input  wire logic                   dramAccessBusy,
	input  wire logic                   refreshDone,
	output logic                        refreshRequest,
	output logic                        selfRefresh,
	output logic                        matchInterrupt,
	output drc_pkg::drc_timing_type     timing
);

	logic [15:0] dramCfg_q;
	logic [15:0] refCtl_q;
	logic [7:0]  refCnt_q;
	logic [7:0]  refPer_q;
	logic        touched_q;
	logic        flagSeen_q;
	logic [drc_pkg::DivWidth-1:0] div_q;
	logic [drc_pkg::DivWidth-1:0] divPrev_q;
	logic        reqPend_q;
	logic        selfRef_q;
	logic        countTick;
	logic        match;
	logic        wrCfg;
	logic        wrCtl;
	logic        wrCnt;
	logic        wrPer;
	logic        rdCtl;
	logic [15:0] rdData_d;
	drc_pkg::drc_cfg_type cfg;

	function automatic logic [3:0] tapIndex(input logic [2:0] sel);
		tapIndex = 4'd0;
		unique case (sel)
			3'd1: tapIndex = 4'd0;
			3'd2: tapIndex = 4'd2;
			3'd3: tapIndex = 4'd4;
			3'd4: tapIndex = 4'd6;
			3'd5: tapIndex = 4'd8;
			3'd6: tapIndex = 4'd10;
			3'd7: tapIndex = 4'd11;
			default: tapIndex = 4'd0;
		endcase
	endfunction

	assign wrCfg = regWrite && regAddr == drc_pkg::RegDramCfgIdx;
	assign wrCtl = regWrite && regAddr == drc_pkg::RegRefCtlIdx;
	assign wrCnt = regWrite && regAddr == drc_pkg::RegRefCntIdx;
	assign wrPer = regWrite && regAddr == drc_pkg::RegRefPerIdx;
	assign rdCtl = regRead && regAddr == drc_pkg::RegRefCtlIdx;

	// Configuration register; reserved bits are masked on write.
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			dramCfg_q <= drc_pkg::DramCfgReset;
		end else if (wrCfg) begin
			dramCfg_q <= regWrData & drc_pkg::DramCfgWrMask;
		end
	end

	assign cfg = drc_pkg::drc_cfg_type'({dramCfg_q[15:7],
		dramCfg_q[5:4], dramCfg_q[2:0]});

	drc_timing_decode decoder (
		.cfg    (cfg),
		.timing (timing)
	);

	// Free-running prescaler; a tick is the rising of the chosen tap.
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			div_q <= '0;
			divPrev_q <= '0;
		end else begin
			div_q <= div_q + 1'b1;
			divPrev_q <= div_q;
		end
	end

	logic [2:0] clkSel;
	assign clkSel = refCtl_q[drc_pkg::PosClkSel +: 3];
	assign countTick = clkSel != 3'd0
		&& div_q[tapIndex(clkSel)]
		&& !divPrev_q[tapIndex(clkSel)];

	// The reset-value equality is not a real match until something moves.
	assign match = touched_q && refCnt_q == refPer_q;

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			touched_q <= 1'b0;
		end else if (wrCnt || wrPer || countTick) begin
			touched_q <= 1'b1;
		end
	end

	// Counter: software write wins over counting; match clears it.
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			refCnt_q <= 8'h00;
		end else if (wrCnt) begin
			refCnt_q <= regWrData[7:0];
		end else if (match) begin
			refCnt_q <= 8'h00;
		end else if (countTick) begin
			refCnt_q <= refCnt_q + 8'h01;
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			refPer_q <= 8'h00;
		end else if (wrPer) begin
			refPer_q <= regWrData[7:0];
		end
	end

	// Remember that the flag was read as one, enabling the clear.
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			flagSeen_q <= 1'b0;
		end else if (rdCtl && refCtl_q[drc_pkg::PosMatchFlag]) begin
			flagSeen_q <= 1'b1;
		end else if (wrCtl || !refCtl_q[drc_pkg::PosMatchFlag]) begin
			flagSeen_q <= 1'b0;
		end
	end

	// Control register; a new match wins over a clearing write.
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			refCtl_q <= drc_pkg::RefCtlReset;
		end else begin
			if (wrCtl) begin
				refCtl_q[5:0] <= regWrData[5:0];
			end
			if (match) begin
				refCtl_q[drc_pkg::PosMatchFlag] <= 1'b1;
			end else if (wrCtl && flagSeen_q
				&& !regWrData[drc_pkg::PosMatchFlag]) begin
				refCtl_q[drc_pkg::PosMatchFlag] <= 1'b0;
			end
		end
	end

	logic refEn;
	logic refMode;
	assign refEn = refCtl_q[drc_pkg::PosRefEn];
	assign refMode = refCtl_q[drc_pkg::PosRefMode];

	// Pending CBR request; a later match simply replaces it.
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			reqPend_q <= 1'b0;
		end else if (!refEn || selfRef_q) begin
			reqPend_q <= 1'b0;
		end else if (match && !refMode) begin
			reqPend_q <= 1'b1;
		end else if (refreshDone) begin
			reqPend_q <= 1'b0;
		end
	end

	// Self-refresh waits for the current access to finish.
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			selfRef_q <= 1'b0;
		end else if (!(refEn && refMode)) begin
			selfRef_q <= 1'b0;
		end else if (!dramAccessBusy) begin
			selfRef_q <= 1'b1;
		end
	end

	assign refreshRequest = reqPend_q;
	assign selfRefresh = selfRef_q;
	assign matchInterrupt = refCtl_q[drc_pkg::PosMatchFlag]
		&& refCtl_q[drc_pkg::PosMatchIe];

	// Read mux; unmapped addresses read zero.
	always_comb begin
		rdData_d = 16'h0000;
		unique case (regAddr)
			drc_pkg::RegDramCfgIdx: rdData_d = dramCfg_q;
			drc_pkg::RegRefCtlIdx:  rdData_d = refCtl_q & 16'h007F;
			drc_pkg::RegRefCntIdx:  rdData_d = {8'h00, refCnt_q};
			drc_pkg::RegRefPerIdx:  rdData_d = {8'h00, refPer_q};
			default:                rdData_d = 16'h0000;
		endcase
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			regRdData <= 16'h0000;
		end else if (regRead) begin
			regRdData <= rdData_d;
		end else begin
			regRdData <= 16'h0000;
		end
	end

	match_clears_counter_a: assert property (
		@(posedge ref_clk) disable iff (reset)
		match && !wrCnt |=> refCnt_q == 8'h00)
		else $error("Counter not cleared after match.");

	match_sets_flag_a: assert property (
		@(posedge ref_clk) disable iff (reset)
		match |=> refCtl_q[drc_pkg::PosMatchFlag])
		else $error("Match flag not set.");

	untouched_no_match_a: assert property (
		@(posedge ref_clk) disable iff (reset)
		!touched_q |-> !match && !refCtl_q[drc_pkg::PosMatchFlag])
		else $error("Match raised from reset values.");

	flag_clear_needs_read_a: assert property (
		@(posedge ref_clk) disable iff (reset)
		$fell(refCtl_q[drc_pkg::PosMatchFlag]) |->
		$past(wrCtl) && $past(flagSeen_q))
		else $error("Flag cleared without prior read.");

	irq_follows_flag_a: assert property (
		@(posedge ref_clk) disable iff (reset)
		match && refCtl_q[drc_pkg::PosMatchIe] && !wrCtl
		|=> matchInterrupt)
		else $error("Interrupt does not follow flag and enable.");

	irq_held_a: assert property (
		@(posedge ref_clk) disable iff (reset)
		matchInterrupt && refCtl_q[5] && !wrCtl |=> matchInterrupt)
		else $error("Interrupt dropped without flag clear.");

	stopped_counter_a: assert property (
		@(posedge ref_clk) disable iff (reset)
		clkSel == 3'd0 && !wrCnt && !match |=> $stable(refCnt_q))
		else $error("Counter moved while stopped.");

	self_ref_entry_a: assert property (
		@(posedge ref_clk) disable iff (reset)
		refEn && refMode && !dramAccessBusy |=> selfRef_q)
		else $error("Self-refresh not entered when idle.");

	no_req_self_a: assert property (
		@(posedge ref_clk) disable iff (reset)
		selfRef_q |=> !reqPend_q)
		else $error("Refresh request during self-refresh.");

	no_refresh_off_a: assert property (
		@(posedge ref_clk) disable iff (reset)
		!refEn |=> !reqPend_q && !selfRef_q)
		else $error("Refresh active while disabled.");

	cfg_reserved_zero_a: assert property (
		@(posedge ref_clk) disable iff (reset)
		dramCfg_q[6] == 1'b0 && dramCfg_q[3] == 1'b0)
		else $error("Reserved configuration bit set.");

	ctl_reserved_zero_a: assert property (
		@(posedge ref_clk) disable iff (reset)
		regRead && regAddr == drc_pkg::RegRefCtlIdx
		|=> regRdData[15:7] == 9'h000)
		else $error("Reserved control bits read nonzero.");

	count_upper_zero_a: assert property (
		@(posedge ref_clk) disable iff (reset)
		regRead && regAddr == drc_pkg::RegRefCntIdx
		|=> regRdData[15:8] == 8'h00)
		else $error("Counter upper byte read nonzero.");

	period_upper_zero_a: assert property (
		@(posedge ref_clk) disable iff (reset)
		regRead && regAddr == drc_pkg::RegRefPerIdx
		|=> regRdData[15:8] == 8'h00)
		else $error("Period upper byte read nonzero.");

	tick_counts_up_a: assert property (
		@(posedge ref_clk) disable iff (reset)
		countTick && !wrCnt && !match
		|=> refCnt_q == $past(refCnt_q) + 8'h01)
		else $error("Counter did not advance on tick.");

	no_tick_stopped_a: assert property (
		@(posedge ref_clk) disable iff (reset)
		clkSel == 3'd0 |-> !countTick)
		else $error("Tick while count clock stopped.");

	fast_tick_gap_a: assert property (
		@(posedge ref_clk) disable iff (reset)
		countTick && clkSel == 3'd1 && !wrCtl |=> !countTick)
		else $error("Half-rate tick came too soon.");

	request_on_match_a: assert property (
		@(posedge ref_clk) disable iff (reset)
		match && refEn && !refMode && !selfRef_q |=> reqPend_q)
		else $error("Match did not raise a refresh request.");

	request_held_a: assert property (
		@(posedge ref_clk) disable iff (reset)
		reqPend_q && refEn && !selfRef_q && !refreshDone
		|=> reqPend_q)
		else $error("Refresh request dropped unserviced.");

	self_ref_waits_a: assert property (
		@(posedge ref_clk) disable iff (reset)
		!selfRef_q && dramAccessBusy |=> !selfRef_q)
		else $error("Self-refresh entered during an access.");

	flag_only_by_match_a: assert property (
		@(posedge ref_clk) disable iff (reset)
		!refCtl_q[drc_pkg::PosMatchFlag] && !match
		|=> !refCtl_q[drc_pkg::PosMatchFlag])
		else $error("Match flag set without a match.");

	row_cycles_default_a: assert property (
		@(posedge ref_clk) disable iff (reset)
		!dramCfg_q[drc_pkg::PosRasCas] |-> timing.rowCycles == 2'd1)
		else $error("Row address cycles wrong.");

endmodule

// >>> src/drc_timing_decode.sv
// Decoder turning the DRAM configuration fields into timing values.
`timescale 1ns/1ps
module drc_timing_decode (
	input  drc_pkg::drc_cfg_type    cfg,
	output drc_pkg::drc_timing_type timing
);

	// Precharge and CBR RAS timings are in half cycles so that x.5 figures stay exact.
	always_comb begin
		timing.prechargeHalf = drc_pkg::PrechargeHalfBase
			+ {2'b00, cfg.prechargeSelect, 1'b0};
		timing.rowCycles = cfg.rasCasDelaySelect ? 2'd2 : 2'd1;
		timing.cbrRasHalf = drc_pkg::CbrRasHalfBase
			+ {1'b0, cfg.cbrRasWidth, 1'b0};
		timing.writeCycles = drc_pkg::ColCyclesBase
			+ {1'b0, cfg.writeColumnCycles};
		timing.readCycles = drc_pkg::ColCyclesBase
			+ {1'b0, cfg.readColumnCycles};
		timing.writeWaitOn = cfg.writeColumnCycles[1];
		timing.readWaitOn = cfg.readColumnCycles[1];
		timing.idleAfterRead = cfg.idleAfterRead;
		timing.pageMode = cfg.pageModeEnable;
		timing.rasDown = cfg.rasHoldMode;
		timing.wide = cfg.dramWidthSelect;
		timing.rowShift = drc_pkg::RowShiftBase
			+ {2'b00, cfg.rowShiftSelect};
	end

endmodule

// >>> tb/drc_dram_model.sv
// Behavioural model of the DRAM side: access traffic and refresh completion.
`timescale 1ns/1ps
module drc_dram_model (
	input  wire logic       ref_clk,
	input  wire logic       reset,
	input  wire logic       accessGo,
	input  wire logic [3:0] delay,
	input  wire logic       refreshRequest,
	output logic            dramAccessBusy,
	output logic            refreshDone
);
	logic [3:0] busyCnt;
	logic [3:0] refCnt;

	assign dramAccessBusy = busyCnt != 4'h0;

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			busyCnt <= 4'h0;
		end else if (accessGo) begin
			busyCnt <= delay;
		end else if (busyCnt != 4'h0) begin
			busyCnt <= busyCnt - 4'h1;
		end
	end

	// A slow delay lets a pending request wait across several cycles.
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			refCnt <= 4'h0;
			refreshDone <= 1'b0;
		end else if (refreshDone || !refreshRequest) begin
			refCnt <= 4'h0;
			refreshDone <= 1'b0;
		end else if (refCnt == delay) begin
			refreshDone <= 1'b1;
		end else begin
			refCnt <= refCnt + 4'h1;
		end
	end
endmodule

// >>> tb/tb_top.sv
// Self-checking testbench for the DRAM timing and refresh control block.
`timescale 1ns/1ps
module tb_top;
	logic                    ref_clk, reset, regWrite, regRead;
	logic                    accessGo, rdSeen, refreshDone;
	logic                    dramAccessBusy, refreshRequest;
	logic                    selfRefresh, matchInterrupt;
	logic [3:0]              regAddr, delay;
	logic [15:0]             regWrData, regRdData, v;
	drc_pkg::drc_timing_type timing, e;
	logic [15:0]             expQ[$];
	int                      n_mismatch, compares, cyc, n;

	drc_refresh_control drc_refresh_control_i (
		.ref_clk(ref_clk), .reset(reset), .regAddr(regAddr),
		.regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
		.regRdData(regRdData), .dramAccessBusy(dramAccessBusy),
		.refreshDone(refreshDone), .refreshRequest(refreshRequest),
		.selfRefresh(selfRefresh), .matchInterrupt(matchInterrupt),
		.timing(timing));

	drc_dram_model drc_dram_model_i (
		.ref_clk(ref_clk), .reset(reset), .accessGo(accessGo),
		.delay(delay), .refreshRequest(refreshRequest),
		.dramAccessBusy(dramAccessBusy), .refreshDone(refreshDone));

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	task automatic test_done;
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Strobes drop for a cycle so no signal is assigned twice per step.
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'b1;
		@(posedge ref_clk);
		regWrite <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic rd(input logic [3:0] a, input logic [15:0] d);
		expQ.push_back(d);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge ref_clk);
		regRead <= 1'b0;
		@(posedge ref_clk);
	endtask

	always @(posedge ref_clk) begin
		if (rdSeen) check(regRdData, expQ.pop_front());
		rdSeen <= regRead;
	end

	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_mismatch++;
			test_done();
		end
	end

	initial begin
		v = 16'($urandom(32'h4d81));
		reset = 1'b1;
		regWrite = 1'b0;
		regRead = 1'b0;
		accessGo = 1'b0;
		rdSeen = 1'b0;
		regAddr = 4'h0;
		regWrData = 16'h0000;
		delay = 4'h3;
		repeat (5) @(posedge ref_clk);
		reset <= 1'b0;
		@(posedge ref_clk);
		rd(4'h0, 16'h0000);
		rd(4'h1, 16'h0000);
		wr(4'h1, 16'h0002);
		repeat (8) @(posedge ref_clk);
		check(refreshRequest, 1'b0);
		rd(4'h1, 16'h0002);
		wr(4'h0, 16'hFFFF);
		rd(4'h0, 16'hFFB7);
		wr(4'h7, 16'hFFFF);
		rd(4'h7, 16'h0000);
		for (int i = 0; i < 12; i++) begin
			v = {i[0], i[1], {3{i[1:0]}}, i[0], 1'b0, i[1], i[0], 1'b0,
				i[1], i[1:0]};
			if (i > 3) v = 16'($urandom) & 16'hFFB7;
			wr(4'h0, v);
			e = '0;
			e.prechargeHalf = 4'h3 + {v[15], 1'b0};
			e.rowCycles = 2'h1 + {1'b0, v[14]};
			e.cbrRasHalf = 4'h5 + {1'b0, v[13:12], 1'b0};
			e.writeCycles = 3'h2 + {1'b0, v[11:10]};
			e.readCycles = 3'h2 + {1'b0, v[9:8]};
			e.writeWaitOn = v[11];
			e.readWaitOn = v[9];
			e.idleAfterRead = v[7];
			e.pageMode = v[5];
			e.rasDown = v[4];
			e.wide = v[2];
			e.rowShift = 4'h9 + {2'h0, v[1:0]};
			check(timing, e);
			rd(4'h0, v);
		end
		wr(4'h3, 16'hFFFF);
		rd(4'h3, 16'h00FF);
		wr(4'h2, 16'h12A5);
		repeat (4) @(posedge ref_clk);
		rd(4'h2, 16'h00A5);
		wr(4'h3, 16'h0020);
		wr(4'h2, 16'h0000);
		delay <= 4'($urandom_range(9, 2));
		wr(4'h1, 16'h0026);
		for (n = 0; n < 200 && refreshRequest !== 1'b1; n++) @(posedge ref_clk);
		check(refreshRequest, 1'b1);
		check(matchInterrupt, 1'b1);
		for (n = 0; n < 40 && refreshRequest !== 1'b0; n++) @(posedge ref_clk);
		check(refreshRequest, 1'b0);
		wr(4'h1, 16'h0022);
		check(matchInterrupt, 1'b1);
		rd(4'h1, 16'h0062);
		wr(4'h1, 16'h0022);
		rd(4'h1, 16'h0022);
		check(matchInterrupt, 1'b0);
		delay <= 4'hA;
		accessGo <= 1'b1;
		@(posedge ref_clk);
		accessGo <= 1'b0;
		wr(4'h1, 16'h0007);
		check(selfRefresh, 1'b0);
		for (n = 0; n < 40 && selfRefresh !== 1'b1; n++) @(posedge ref_clk);
		check(selfRefresh, 1'b1);
		check(dramAccessBusy, 1'b0);
		repeat (100) @(posedge ref_clk);
		check(refreshRequest, 1'b0);
		check(matchInterrupt, 1'b0);
		rd(4'h1, 16'h0047);
		// Counter is zeroed before the slower clock so no match can race.
		wr(4'h2, 16'h0000);
		wr(4'h1, 16'h0008);
		repeat (196) @(posedge ref_clk);
		check(selfRefresh, 1'b0);
		rd(4'h1, 16'h0008);
		repeat (100) @(posedge ref_clk);
		rd(4'h1, 16'h0048);
		reset <= 1'b1;
		repeat (2) @(posedge ref_clk);
		reset <= 1'b0;
		@(posedge ref_clk);
		rd(4'h0, 16'h0000);
		rd(4'h1, 16'h0000);
		// Let the monitor take the last read before the verdict.
		@(posedge ref_clk);
		test_done();
	end
endmodule
